//--- src/gos_pkg.sv
// Purpose: shared constants and types for the gyro output sequencer
// Assumes: 40 MHz clock, 2000 samples/s internal rate
// Notes:   rate values are 24-bit two's complement, lsb 2^-14 deg/s
`default_nettype none

package gos_pkg;

  // clock and sample timing
  localparam int CLK_HZ         = 40_000_000;
  localparam int SAMPLE_HZ      = 2000;
  localparam int SAMPLE_CYCLES  = CLK_HZ / SAMPLE_HZ;
  localparam int US_PER_S       = 1_000_000;
  localparam int US_CYCLES      = CLK_HZ / US_PER_S;
  localparam int SETTLE_US      = 1000;
  localparam int SETTLE_CYCLES  = SETTLE_US * US_CYCLES;
  localparam int STARTUP_US     = 1000000;
  localparam int STARTUP_CYCLES = STARTUP_US * US_CYCLES;

  // datagram layout
  localparam int RATE_W         = 24;
  localparam int STATUS_W       = 8;
  localparam int STARTUP_BIT    = 6;
  localparam int LAT_W          = 16;
  localparam int DIV_W          = 11;
  localparam int ID_COUNT       = 3;

  // arithmetic: angle lsb 2^-21 deg = rate sum * 8 / 125
  localparam int ACC_W          = 40;
  localparam int INT_W          = 30;
  localparam int ANGLE_SHIFT    = 3;
  localparam logic signed [ACC_W-1:0] ANGLE_DEN = 40'sh000000007d;
  localparam logic signed [INT_W-1:0] INT_MOD   = 30'sh0fa00000;
  localparam logic signed [INT_W-1:0] INT_HALF  = 30'sh07d00000;

  typedef enum logic [1:0] {
    GOS_FN_RATE,
    GOS_FN_INCR,
    GOS_FN_AVG,
    GOS_FN_INTEG
  } gos_func_t;

  typedef enum logic [1:0] {
    GOS_DG_SENSOR,
    GOS_DG_PART,
    GOS_DG_SERIAL,
    GOS_DG_CONFIG
  } gos_kind_t;

  typedef enum logic [1:0] {
    GOS_ST_SETTLE,
    GOS_ST_SYNC,
    GOS_ST_IDENT,
    GOS_ST_NORMAL
  } gos_mode_t;

  typedef struct packed {
    logic              trigMode;
    gos_func_t         func;
    logic [DIV_W-1:0]  outDiv;
  } gos_cfg_t;

  typedef struct packed {
    gos_kind_t            kind;
    logic [7:0]           rateByteHigh;
    logic [7:0]           rateByteMid;
    logic [7:0]           rateByteLow;
    logic [STATUS_W-1:0]  status;
    logic [LAT_W-1:0]     latency;
  } gos_dgram_t;

endpackage

`default_nettype wire

//--- src/gos_accum.sv
// Purpose: per-transmission output functions on the sample stream
// Assumes: one sample per sampleValid pulse at the internal rate
// Notes:   result is combinational, latched by the sequencer at issue
`default_nettype none

module gos_accum (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  // control
  input  wire logic                       clear,
  input  wire logic                       take,
  input  wire gos_pkg::gos_func_t         func,
  // samples
  input  wire logic                       sampleValid,
  input  wire logic signed [23:0]         sampleData,
  // result
  output logic         [23:0]             result
);

  logic signed [gos_pkg::ACC_W-1:0] sumQ, sumD, sampExt, incrFull, avgFull, cntExt;
  logic signed [gos_pkg::INT_W-1:0] integQ, integD, integSum;
  logic signed [gos_pkg::ACC_W-1:0] integFull;
  logic        [11:0]               cntQ, cntD;
  logic        [23:0]               lastQ, lastD;

  assign sampExt = gos_pkg::ACC_W'(sampleData);
  assign cntExt  = $signed({{(gos_pkg::ACC_W-12){1'b0}}, cntQ});

  always_comb begin
    sumD     = sumQ;
    cntD     = cntQ;
    integD   = integQ;
    lastD    = lastQ;
    integSum = integQ + gos_pkg::INT_W'(sampleData);
    if (sampleValid) begin
      lastD = sampleData;
      sumD  = sumQ + sampExt;
      cntD  = cntQ + 12'h001;
      if (integSum >= gos_pkg::INT_HALF) begin
        integD = integSum - gos_pkg::INT_MOD;
      end else if (integSum < -gos_pkg::INT_HALF) begin
        integD = integSum + gos_pkg::INT_MOD;
      end else begin
        integD = integSum;
      end
    end
    if (take) begin
      sumD = sampleValid ? sampExt : '0;
      cntD = sampleValid ? 12'h001 : 12'h000;
    end
    if (clear) begin
      sumD   = '0;
      cntD   = 12'h000;
      integD = '0;
      lastD  = 24'h000000;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sumQ   <= '0;
      cntQ   <= 12'h000;
      integQ <= '0;
      lastQ  <= 24'h000000;
    end else begin
      sumQ   <= sumD;
      cntQ   <= cntD;
      integQ <= integD;
      lastQ  <= lastD;
    end
  end

  assign incrFull  = (sumQ <<< gos_pkg::ANGLE_SHIFT) / gos_pkg::ANGLE_DEN;
  assign avgFull   = (cntQ == 12'h000) ? gos_pkg::ACC_W'($signed(lastQ))
                                       : sumQ / cntExt;
  assign integFull = (gos_pkg::ACC_W'(integQ) <<< gos_pkg::ANGLE_SHIFT)
                     / gos_pkg::ANGLE_DEN;

  always_comb begin
    case (func)
      gos_pkg::GOS_FN_RATE:  result = lastQ;
      gos_pkg::GOS_FN_INCR:  result = incrFull[23:0];
      gos_pkg::GOS_FN_AVG:   result = avgFull[23:0];
      gos_pkg::GOS_FN_INTEG: result = integFull[23:0];
      default:               result = lastQ;
    endcase
  end

endmodule // gos_accum

`default_nettype wire

//--- src/gos_gyro_output_sequencer.sv
// Purpose: mode control and datagram sequencing of a gyro module
// Assumes: serializer outside frames datagrams and reports the last bit
// Notes:   pins are synchronous to clk; long counts are parameters
`default_nettype none

// What this block does
// - in trigger mode, one sensor datagram per falling trigger edge
// - a pending special datagram replaces the sensor datagram at the trigger
// - several special requests before a trigger keep only the newest one
// - init mode sends its three identification datagrams without any trigger
// - latency counts microseconds from last filtered sample to the trigger
// - validity strobe falls in step with the output sample rate
// - outside trigger mode, validity strobe rises only after the last datagram bit leaves, or when a reset forces init
// - in trigger mode the strobe does not mark transmissions
// - init on power-on, reset pin, reset command, or service exit to init
// - init waits for settling, then syncs channels, then sends identification
// - part, serial, configuration datagrams in that order, then normal mode
// - normal mode sends identification datagrams on host request
// - normal mode samples at 2000/s, sends at output rate or on trigger
// - datagrams keep flowing whatever the status byte reports
// - status bit 6 stays set for the start-up period after init
// - service exit straight to normal skips start-up and its flag
// - incremental output sums samples times sample period since last send
// - average output is the mean of samples since last send
// - integrated output accumulates since reset, wrapping within four degrees
// - rate output is the newest sample, others discarded
// - rate is 24-bit two's complement, high byte first
// - reset pin low holds the device in init mode
// - sampling keeps running at the full internal rate in trigger mode
module gos_gyro_output_sequencer #(
  parameter int SAMPLE_CYCLES  = gos_pkg::SAMPLE_CYCLES,
  parameter int SETTLE_CYCLES  = gos_pkg::SETTLE_CYCLES,
  parameter int STARTUP_CYCLES = gos_pkg::STARTUP_CYCLES
) (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  // host pins
  input  wire logic                          hardReset_n,
  input  wire logic                          sampleRequestIn,
  // commands from the serial receiver
  input  wire logic                          resetCmd,
  input  wire logic                          identReq,
  input  wire gos_pkg::gos_kind_t            identReqKind,
  input  wire logic                          serviceExitInit,
  input  wire logic                          serviceExitNormal,
  // configuration
  input  wire gos_pkg::gos_cfg_t             cfg,
  // filtered samples and diagnostics
  input  wire logic                          sampleValid,
  input  wire logic signed [23:0]            sampleData,
  input  wire logic [gos_pkg::STATUS_W-1:0]  statusIn,
  // serializer
  input  wire logic                          txBusy,
  input  wire logic                          txLastBit,
  // outputs
  output logic                               txStart_q,
  output gos_pkg::gos_dgram_t                txDgram_q,
  output logic                               validityTimeStrobe_q,
  output logic                               sampleTick_q,
  output logic                               chanSync_q,
  output logic                               normalMode_q
);

  gos_pkg::gos_mode_t   mode_q, mode_d;
  gos_pkg::gos_kind_t   pendKind_q, pendKind_d;
  gos_pkg::gos_dgram_t  txDgram_d;
  logic [31:0]          sampCnt_q, sampCnt_d, settleCnt_q, settleCnt_d;
  logic [31:0]          startCnt_q, startCnt_d;
  logic [gos_pkg::DIV_W-1:0] outCnt_q, outCnt_d, divM1;
  logic [5:0]           usCnt_q, usCnt_d;
  logic [gos_pkg::LAT_W-1:0] latUs_q, latUs_d;
  logic [1:0]           idIdx_q, idIdx_d;
  logic                 pend_q, pend_d, await_q, await_d, startup_q, startup_d;
  logic                 trigPrev_q, trigPrev_d, tov_d, txStart_d, chanSync_d, normal_d;
  logic                 tick, outTick, trigFall, canIssue, sendEv, issue, take, accClear;
  gos_pkg::gos_kind_t   issueKind;
  logic [23:0]          accResult;
  logic [gos_pkg::STATUS_W-1:0] statusOut;

  gos_accum u_accum (
    .clk         (clk),
    .rst_n       (rst_n),
    .clear       (accClear),
    .take        (take),
    .func        (cfg.func),
    .sampleValid (sampleValid),
    .sampleData  (sampleData),
    .result      (accResult)
  );

  assign divM1     = (cfg.outDiv == '0) ? '0 : cfg.outDiv - 1'b1;
  assign tick      = (sampCnt_q == 32'(SAMPLE_CYCLES - 1));
  assign outTick   = tick && (outCnt_q >= divM1);
  assign trigFall  = trigPrev_q && !sampleRequestIn;
  assign canIssue  = !txBusy && !await_q && !txStart_q;

  always_comb begin
    statusOut = statusIn;
    statusOut[gos_pkg::STARTUP_BIT] = startup_q;
  end

  always_comb begin
    mode_d      = mode_q;
    pendKind_d  = pendKind_q;
    pend_d      = pend_q;
    await_d     = await_q;
    startup_d   = startup_q;
    idIdx_d     = idIdx_q;
    settleCnt_d = settleCnt_q;
    startCnt_d  = startCnt_q;
    outCnt_d    = outCnt_q;
    usCnt_d     = usCnt_q + 6'h01;
    latUs_d     = latUs_q;
    tov_d       = validityTimeStrobe_q;
    txDgram_d   = txDgram_q;
    txStart_d   = 1'b0;
    chanSync_d  = 1'b0;
    trigPrev_d  = sampleRequestIn;
    sampCnt_d   = tick ? 32'h0000_0000 : sampCnt_q + 32'h0000_0001;
    issue       = 1'b0;
    issueKind   = gos_pkg::GOS_DG_SENSOR;
    sendEv      = 1'b0;
    take        = 1'b0;
    accClear    = 1'b0;
    // microseconds since the last filtered sample
    if (usCnt_q == 6'(gos_pkg::US_CYCLES - 1)) begin
      usCnt_d = 6'h00;
      if (latUs_q != '1) begin
        latUs_d = latUs_q + 16'h0001;
      end
    end
    if (sampleValid) begin
      usCnt_d = 6'h00;
      latUs_d = 16'h0000;
    end
    if (tick) begin
      outCnt_d = outTick ? '0 : outCnt_q + 1'b1;
    end
    if (txLastBit) begin
      await_d = 1'b0;
    end
    case (mode_q)
      gos_pkg::GOS_ST_SETTLE: begin
        settleCnt_d = settleCnt_q + 32'h0000_0001;
        if (settleCnt_q >= 32'(SETTLE_CYCLES - 1)) begin
          mode_d = gos_pkg::GOS_ST_SYNC;
        end
      end
      gos_pkg::GOS_ST_SYNC: begin
        chanSync_d = 1'b1;
        sampCnt_d  = 32'h0000_0000;
        outCnt_d   = '0;
        idIdx_d    = 2'h0;
        mode_d     = gos_pkg::GOS_ST_IDENT;
      end
      gos_pkg::GOS_ST_IDENT: begin
        if (idIdx_q < 2'(gos_pkg::ID_COUNT)) begin
          if (canIssue) begin
            issue     = 1'b1;
            issueKind = gos_pkg::gos_kind_t'(idIdx_q + 2'h1);
            idIdx_d   = idIdx_q + 2'h1;
          end
        end else if (!await_q && !txBusy && !txStart_q) begin
          mode_d     = gos_pkg::GOS_ST_NORMAL;
          startup_d  = 1'b1;
          startCnt_d = 32'h0000_0000;
        end
      end
      gos_pkg::GOS_ST_NORMAL: begin
        if (startup_q) begin
          startCnt_d = startCnt_q + 32'h0000_0001;
          if (startCnt_q >= 32'(STARTUP_CYCLES - 1)) begin
            startup_d = 1'b0;
          end
        end
        sendEv = cfg.trigMode ? trigFall : outTick;
        if (sendEv && canIssue) begin
          issue     = 1'b1;
          issueKind = pend_q ? pendKind_q : gos_pkg::GOS_DG_SENSOR;
          pend_d    = 1'b0;
          take      = !pend_q;
        end
        if (identReq && identReqKind != gos_pkg::GOS_DG_SENSOR) begin
          pend_d     = 1'b1;
          pendKind_d = identReqKind;
        end
        if (cfg.trigMode) begin
          if (outTick) begin
            tov_d = 1'b0;
          end else if (tick) begin
            tov_d = 1'b1;
          end
        end else begin
          if (txLastBit) begin
            tov_d = 1'b1;
          end
          if (outTick) begin
            tov_d = 1'b0;
          end
        end
      end
      default: begin
        mode_d = gos_pkg::GOS_ST_SETTLE;
      end
    endcase
    if (issue) begin
      txStart_d              = 1'b1;
      await_d                = 1'b1;
      txDgram_d.kind         = issueKind;
      txDgram_d.rateByteHigh = accResult[23:16];
      txDgram_d.rateByteMid  = accResult[15:8];
      txDgram_d.rateByteLow  = accResult[7:0];
      txDgram_d.status       = statusOut;
      txDgram_d.latency      = latUs_q;
    end
    if (serviceExitNormal) begin
      mode_d    = gos_pkg::GOS_ST_NORMAL;
      startup_d = 1'b0;
    end
    if (!hardReset_n || serviceExitInit ||
        (resetCmd && mode_q == gos_pkg::GOS_ST_NORMAL)) begin
      mode_d      = gos_pkg::GOS_ST_SETTLE;
      settleCnt_d = 32'h0000_0000;
      pend_d      = 1'b0;
      await_d     = 1'b0;
      startup_d   = 1'b0;
      tov_d       = 1'b1;
      txStart_d   = 1'b0;
      accClear    = 1'b1;
    end
  end

  assign normal_d = (mode_d == gos_pkg::GOS_ST_NORMAL);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_q               <= gos_pkg::GOS_ST_SETTLE;
      pendKind_q           <= gos_pkg::GOS_DG_SENSOR;
      pend_q               <= 1'b0;
      await_q              <= 1'b0;
      startup_q            <= 1'b0;
      idIdx_q              <= 2'h0;
      settleCnt_q          <= 32'h0000_0000;
      startCnt_q           <= 32'h0000_0000;
      sampCnt_q            <= 32'h0000_0000;
      outCnt_q             <= '0;
      usCnt_q              <= 6'h00;
      latUs_q              <= 16'h0000;
      trigPrev_q           <= 1'b1;
      txStart_q            <= 1'b0;
      txDgram_q            <= '0;
      validityTimeStrobe_q <= 1'b1;
      sampleTick_q         <= 1'b0;
      chanSync_q           <= 1'b0;
      normalMode_q         <= 1'b0;
    end else begin
      mode_q               <= mode_d;
      pendKind_q           <= pendKind_d;
      pend_q               <= pend_d;
      await_q              <= await_d;
      startup_q            <= startup_d;
      idIdx_q              <= idIdx_d;
      settleCnt_q          <= settleCnt_d;
      startCnt_q           <= startCnt_d;
      sampCnt_q            <= sampCnt_d;
      outCnt_q             <= outCnt_d;
      usCnt_q              <= usCnt_d;
      latUs_q              <= latUs_d;
      trigPrev_q           <= trigPrev_d;
      txStart_q            <= txStart_d;
      txDgram_q            <= txDgram_d;
      validityTimeStrobe_q <= tov_d;
      sampleTick_q         <= tick;
      chanSync_q           <= chanSync_d;
      normalMode_q         <= normal_d;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic okCtl;
  assign okCtl = hardReset_n && !serviceExitInit && !serviceExitNormal && !resetCmd;

  a_trig_one_dgram: assert property (mode_q == gos_pkg::GOS_ST_NORMAL && cfg.trigMode && okCtl
    && trigFall && canIssue |=> txStart_q && txDgram_q.latency == $past(latUs_q))
    else $error("trigger edge did not start a datagram");
  a_special_replaces: assert property (mode_q == gos_pkg::GOS_ST_NORMAL && okCtl && pend_q
    && !identReq && sendEv && canIssue
    |=> txStart_q && txDgram_q.kind == $past(pendKind_q) && !pend_q)
    else $error("pending special datagram not sent in place of sensor data");
  a_newest_request: assert property (mode_q == gos_pkg::GOS_ST_NORMAL && okCtl && identReq
    && identReqKind != gos_pkg::GOS_DG_SENSOR |=> pend_q && pendKind_q == $past(identReqKind))
    else $error("newest special request not kept");
  a_init_untriggered: assert property (mode_q == gos_pkg::GOS_ST_IDENT && okCtl
    && idIdx_q < 2'h3 && canIssue |=> txStart_q)
    else $error("identification datagram waited");
  a_ident_order: assert property (txStart_q && $past(mode_q) == gos_pkg::GOS_ST_IDENT
    |-> txDgram_q.kind == gos_pkg::gos_kind_t'(idIdx_q))
    else $error("identification datagrams out of order");
  a_tov_rise_last: assert property ($rose(validityTimeStrobe_q) && !$past(cfg.trigMode)
    && $past(okCtl) |-> $past(txLastBit))
    else $error("validity strobe rose before last bit");
  a_tov_fall_sync: assert property ($fell(validityTimeStrobe_q) |-> sampleTick_q)
    else $error("validity strobe fell off the sample grid");
  a_reset_pin_init: assert property (!hardReset_n |=> mode_q == gos_pkg::GOS_ST_SETTLE
    && !normalMode_q)
    else $error("reset pin did not force init");
  a_sync_after_settle: assert property (mode_q == gos_pkg::GOS_ST_SYNC
    |-> $past(mode_q) == gos_pkg::GOS_ST_SETTLE ##1 chanSync_q)
    else $error("channel sync out of sequence");
  a_startup_flag: assert property ($past(mode_q) == gos_pkg::GOS_ST_IDENT
    && mode_q == gos_pkg::GOS_ST_NORMAL && $past(okCtl) |-> startup_q)
    else $error("start-up flag missing after init");
  a_service_no_start: assert property (serviceExitNormal && hardReset_n && !serviceExitInit
    && !resetCmd |=> !startup_q && mode_q == gos_pkg::GOS_ST_NORMAL)
    else $error("service exit raised start-up flag");

  c_trig_send: cover property (cfg.trigMode && trigFall && canIssue
    && mode_q == gos_pkg::GOS_ST_NORMAL);
  c_special_sent: cover property (pend_q && issue);
  c_startup_end: cover property ($fell(startup_q));
  c_ident_done: cover property ($rose(normalMode_q));

endmodule // gos_gyro_output_sequencer

`default_nettype wire

//--- tb/gos_host_model.sv
// Purpose: serializer and host stand-in behind the sequencer
// Assumes: each datagram occupies the line for BITS clocks
// Notes:   takes every datagram whatever its status byte says
`default_nettype none

module gos_host_model #(
  parameter int BITS = 8
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // datagram link
  input  wire logic txStart,
  output logic      txBusy,
  output logic      txLastBit
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;

  // line busy, last-bit pulse as the final bit leaves
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt       <= 0;
      txBusy    <= 1'b0;
      txLastBit <= 1'b0;
    end else begin
      txLastBit <= (cnt == 1);
      if (txStart) begin
        cnt    <= BITS;
        txBusy <= 1'b1;
      end else if (cnt > 0) begin
        cnt    <= cnt - 1;
        txBusy <= (cnt > 1);
      end
    end
  end
endmodule  // gos_host_model

`default_nettype wire

//--- tb/testbench.sv
// Purpose: self-checking bench for the gyro output sequencer
// Assumes: 20-cycle samples, 10-cycle settle, 50-cycle start-up
// Notes:   far side comes from gos_host_model
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SC = 20;
  logic clk = 1'b0, rst_n = 1'b0, hardReset_n = 1'b1, sampleRequestIn = 1'b1;
  logic resetCmd = 1'b0, identReq = 1'b0, sampleValid = 1'b0, seenSync = 1'b0;
  logic svcInit = 1'b0, svcNormal = 1'b0;
  logic [23:0] a0;
  logic txBusy, txLastBit, txStart_q, validityTimeStrobe_q;
  logic sampleTick_q, chanSync_q, normalMode_q;
  logic [7:0] statusIn = 8'h81;
  logic signed [23:0] sampleData = 24'h12a5c3;
  gos_pkg::gos_kind_t identReqKind = gos_pkg::GOS_DG_SENSOR;
  gos_pkg::gos_cfg_t cfg = '{1'b1, gos_pkg::GOS_FN_RATE, 11'h002};
  gos_pkg::gos_dgram_t txDgram_q, dg;
  int err_total = 0, n_tests = 0, nStarts = 0, n0;

  gos_gyro_output_sequencer #(.SAMPLE_CYCLES(SC), .SETTLE_CYCLES(10), .STARTUP_CYCLES(50))
    i_gos_gyro_output_sequencer (.clk, .rst_n, .hardReset_n, .sampleRequestIn, .resetCmd,
    .identReq, .identReqKind, .serviceExitInit(svcInit), .serviceExitNormal(svcNormal), .cfg,
    .sampleValid, .sampleData, .statusIn, .txBusy, .txLastBit, .txStart_q, .txDgram_q,
    .validityTimeStrobe_q, .sampleTick_q, .chanSync_q, .normalMode_q);
  gos_host_model i_gos_host_model (.clk, .rst_n, .txStart(txStart_q), .txBusy, .txLastBit);

  initial forever #12.5 clk = ~clk;

  always @(posedge clk) begin
    sampleValid <= sampleTick_q;
    if (txStart_q === 1'b1) nStarts <= nStarts + 1;
    seenSync <= (rst_n & hardReset_n & ~resetCmd & ~svcInit) ? (seenSync | chanSync_q) : 1'b0;
  end

  task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic get_dg(input int lim);
    int i;
    for (i = 0; i < lim && txStart_q !== 1'b1; i++) @(negedge clk);
    check(24'(txStart_q), 24'h1, "datagram start");
    dg = txDgram_q;
    @(negedge clk);
  endtask

  task automatic run_init();
    for (int k = 1; k <= 3; k++) begin
      get_dg(80);
      check(24'(dg.kind), 24'(k), "ident order");
      if (k == 1) check(24'(seenSync), 24'h1, "sync first");
    end
    repeat (12) @(negedge clk);
    check(24'(normalMode_q), 24'h1, "normal mode");
  endtask

  task automatic trig();
    @(posedge clk) sampleRequestIn <= 1'b0;
    @(posedge clk) sampleRequestIn <= 1'b1;
    get_dg(6);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (4000) @(posedge clk);
    err_total++;
    print_verdict();
  end

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    run_init();
    $display("test init done");
    trig();
    check(24'(dg.status), 24'hc1, "start-up flag");
    for (int k = 0; k < 2; k++) begin
      @(posedge clk) sampleData <= k ? 24'hfeee90 : 24'h3a0011;
      repeat (2 * SC + 60) @(negedge clk);
      n0 = nStarts;
      trig();
      check({dg.rateByteHigh, dg.rateByteMid, dg.rateByteLow}, sampleData, "rate");
      check(24'(dg.status), 24'h81, "status");
      check(24'(dg.latency), 24'h0, "latency");
      repeat (2 * SC) @(negedge clk);
      check(24'(nStarts - n0), 24'h1, "one per trigger");
    end
    @(posedge clk) begin
      identReq <= 1'b1;
      identReqKind <= gos_pkg::GOS_DG_PART;
    end
    @(posedge clk) identReqKind <= gos_pkg::GOS_DG_CONFIG;
    @(posedge clk) identReq <= 1'b0;
    repeat (SC) @(negedge clk);
    trig();
    check(24'(dg.kind), 24'(gos_pkg::GOS_DG_CONFIG), "newest request");
    repeat (20) @(negedge clk);
    trig();
    check(24'(dg.kind), 24'(gos_pkg::GOS_DG_SENSOR), "sensor again");
    $display("test trigger done");
    @(posedge clk) cfg <= '{1'b0, gos_pkg::GOS_FN_AVG, 11'h002};
    get_dg(120);
    get_dg(120);
    check({dg.rateByteHigh, dg.rateByteMid, dg.rateByteLow}, sampleData, "average");
    check(24'(validityTimeStrobe_q), 24'h0, "strobe low");
    repeat (12) @(negedge clk);
    check(24'(validityTimeStrobe_q), 24'h1, "strobe high");
    $display("test free running done");
    @(posedge clk) cfg <= '{1'b0, gos_pkg::GOS_FN_INCR, 11'h002};
    get_dg(120);
    get_dg(120);
    check({dg.rateByteHigh, dg.rateByteMid, dg.rateByteLow}, 24'hffdd00, "incr");
    @(posedge clk) cfg <= '{1'b0, gos_pkg::GOS_FN_INTEG, 11'h002};
    get_dg(120);
    a0 = {dg.rateByteHigh, dg.rateByteMid, dg.rateByteLow};
    get_dg(120);
    check({dg.rateByteHigh, dg.rateByteMid, dg.rateByteLow} - a0, 24'hffdd00, "integ");
    $display("test output functions done");
    @(posedge clk) hardReset_n <= 1'b0;
    repeat (3) @(negedge clk);
    check(24'(normalMode_q), 24'h0, "pin reset");
    @(posedge clk) hardReset_n <= 1'b1;
    run_init();
    get_dg(120);
    @(posedge clk) resetCmd <= 1'b1;
    @(posedge clk) resetCmd <= 1'b0;
    run_init();
    @(posedge clk) svcNormal <= 1'b1;
    @(posedge clk) svcNormal <= 1'b0;
    get_dg(120);
    check(24'(dg.status), 24'h81, "no start-up after service exit");
    @(posedge clk) svcInit <= 1'b1;
    @(posedge clk) svcInit <= 1'b0;
    run_init();
    $display("test resets done");
    print_verdict();
  end
endmodule  // testbench

`default_nettype wire
